/* rtl/acs_defs.vh */
`ifndef ACS_DEFS_VH
`define ACS_DEFS_VH

// Register offsets
`define ACS_ADDR_W          8
`define ACS_OFF_SELECT      8'h00
`define ACS_OFF_STEP        8'h04

// Field positions in the channel select register
`define ACS_F0_LSB          5'h00
`define ACS_F1_LSB          5'h04
`define ACS_F2_LSB          5'h08
`define ACS_F3_LSB          5'h0C
`define ACS_F4_LSB          5'h10
`define ACS_F5_LSB          5'h14
`define ACS_CH_W            3

// Reset values
`define ACS_SELECT_RST      32'h0000_0000
`define ACS_STEP_RST        3'h0

// Writable bits of the lower part: fields only, reserved bits stay zero
`define ACS_SELECT_MASK     32'h0077_7777

`endif

/* rtl/acs_seq_select.v */
// Summary of operation
// - Fifth step converts channel in bits 18:16
// - Fourth step converts channel in bits 14:12
// - Third step converts channel in bits 10:8
// - Second step converts channel in bits 6:4
// - First step converts channel in bits 2:0
// - Bits between fields read zero, not writable
// - Field value is the input channel number
//
// The register addresses and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`include "acs_defs.vh"

module acs_seq_select (
    // System clock, rising edge
    input  wire        mclk,
    // Asynchronous reset, active low
    input  wire        resetn,
    // Byte address, held beside either strobe
    input  wire [7:0]  addr,
    // Write data, held beside the write strobe
    input  wire [31:0] wdata,
    // Write strobe, one cycle, never beside the read strobe
    input  wire        wr,
    // Read strobe, one cycle
    input  wire        rd,
    // Read data, valid only in the cycle after the read strobe, else zero
    output reg  [31:0] rdata,
    // Channel number handed to the input multiplexer
    output reg  [2:0]  active_channel,
    // Stored channel of the first step
    output reg  [2:0]  first_step_channel,
    // Stored channel of the second step
    output reg  [2:0]  second_step_channel,
    // Stored channel of the third step
    output reg  [2:0]  third_step_channel,
    // Stored channel of the fourth step
    output reg  [2:0]  fourth_step_channel,
    // Stored channel of the fifth step
    output reg  [2:0]  fifth_step_channel,
    // Stored channel of the sixth step
    output reg  [2:0]  sixth_step_channel
);

    // Decode and field helpers

    // Select register decode; shared by the write and the read path
    function acs_is_select;
        input [7:0] a;
        begin
            acs_is_select = (a == `ACS_OFF_SELECT);
        end
    endfunction

    // Step register decode; shared by the write and the read path
    function acs_is_step;
        input [7:0] a;
        begin
            acs_is_step = (a == `ACS_OFF_STEP);
        end
    endfunction

    // Cut one 3-bit channel field out of a register word
    function [2:0] acs_field;
        input [31:0] word;
        input [4:0]  lsb;
        reg   [31:0] shifted;
        begin
            shifted   = word >> lsb;
            acs_field = shifted[2:0];
        end
    endfunction

    // Internal state and next values

    // Step the sequencer is on; software writes it, 0 is the first step
    reg  [2:0]  seq_step;
    // Value the step register takes at the next edge
    reg  [2:0]  next_seq_step;
    // Values the six fields take at the next edge
    reg  [2:0]  next_first_step_channel;
    reg  [2:0]  next_second_step_channel;
    reg  [2:0]  next_third_step_channel;
    reg  [2:0]  next_fourth_step_channel;
    reg  [2:0]  next_fifth_step_channel;
    reg  [2:0]  next_sixth_step_channel;
    // Channel chosen for the current step
    reg  [2:0]  next_active_channel;
    // Read data for the cycle after a read strobe
    reg  [31:0] next_rdata;
    // Write strobe aimed at the select register
    wire        select_wr;
    // Write strobe aimed at the step register
    wire        step_wr;
    // Read strobe aimed at the select register
    wire        select_rd;
    // Read strobe aimed at the step register
    wire        step_rd;
    // Readback image of the select register
    wire [31:0] select_image;

    // Strobe decodes; an unmapped address hits neither, so it is ignored
    assign select_wr = wr & acs_is_select(addr);
    assign step_wr   = wr & acs_is_step(addr);
    assign select_rd = rd & acs_is_select(addr);
    assign step_rd   = rd & acs_is_step(addr);

    // Reserved bits are constant zero in the image and never stored, so no
    // write can set them and they need no reset value of their own
    assign select_image = {9'h000, sixth_step_channel,
                           1'b0, fifth_step_channel,
                           1'b0, fourth_step_channel,
                           1'b0, third_step_channel,
                           1'b0, second_step_channel,
                           1'b0, first_step_channel};

    // All six fields load from one write; software that wants to change one
    // field reads the word first and writes it back with only that field new
    always @* begin
        next_first_step_channel  = first_step_channel;
        next_second_step_channel = second_step_channel;
        next_third_step_channel  = third_step_channel;
        next_fourth_step_channel = fourth_step_channel;
        next_fifth_step_channel  = fifth_step_channel;
        next_sixth_step_channel  = sixth_step_channel;
        if (select_wr) begin
            // A select write replaces every field at once
            next_first_step_channel  = acs_field(wdata, `ACS_F0_LSB);
            next_second_step_channel = acs_field(wdata, `ACS_F1_LSB);
            next_third_step_channel  = acs_field(wdata, `ACS_F2_LSB);
            next_fourth_step_channel = acs_field(wdata, `ACS_F3_LSB);
            next_fifth_step_channel  = acs_field(wdata, `ACS_F4_LSB);
            next_sixth_step_channel  = acs_field(wdata, `ACS_F5_LSB);
        end
    end

    // Field registers; bits 31:23 are reserved, read zero and are ignored here
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            // Reset clears every field back to channel 0
            first_step_channel  <= 3'h0;
            second_step_channel <= 3'h0;
            third_step_channel  <= 3'h0;
            fourth_step_channel <= 3'h0;
            fifth_step_channel  <= 3'h0;
            sixth_step_channel  <= 3'h0;
        end else begin
            // Otherwise take the values worked out above
            first_step_channel  <= next_first_step_channel;
            second_step_channel <= next_second_step_channel;
            third_step_channel  <= next_third_step_channel;
            fourth_step_channel <= next_fourth_step_channel;
            fifth_step_channel  <= next_fifth_step_channel;
            sixth_step_channel  <= next_sixth_step_channel;
        end
    end

    // Step register: holds its value until software writes a new one
    always @* begin
        next_seq_step = seq_step;
        if (step_wr) begin
            // Only the low three bits are kept
            next_seq_step = wdata[2:0];
        end
    end

    // Step register flop
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            // Sequencer starts at the first step
            seq_step <= `ACS_STEP_RST;
        end else begin
            seq_step <= next_seq_step;
        end
    end

    // Pick the field for the current step; steps 6 and 7 fall to channel 0
    // rather than repeat a field, so a stray step value is easy to spot
    always @* begin
        case (seq_step)
            3'h0:    next_active_channel = first_step_channel;
            3'h1:    next_active_channel = second_step_channel;
            3'h2:    next_active_channel = third_step_channel;
            3'h3:    next_active_channel = fourth_step_channel;
            3'h4:    next_active_channel = fifth_step_channel;
            3'h5:    next_active_channel = sixth_step_channel;
            default: next_active_channel = 3'h0;
        endcase
    end

    // Field value goes to the mux as the channel number, no remap; the
    // register stage keeps the mux select free of decode glitches
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            // Channel 0 while in reset
            active_channel <= 3'h0;
        end else begin
            active_channel <= next_active_channel;
        end
    end

    // Read data: the select image or the step, zero for any other place
    always @* begin
        next_rdata = 32'h0000_0000;
        if (select_rd) begin
            // Mask keeps the reserved bits at zero whatever the image holds
            next_rdata = select_image & `ACS_SELECT_MASK;
        end else if (step_rd) begin
            // Step register reads back in its low three bits
            next_rdata = {29'h0000_0000, seq_step};
        end
    end

    // Read data register; it falls back to zero one cycle after the read
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rdata <= `ACS_SELECT_RST;
        end else begin
            rdata <= next_rdata;
        end
    end

endmodule // acs_seq_select

/* test/acs_analog_model.sv */
`timescale 1ns/1ps
// Each analog pin shows a level that names its own number, so a wrong route shows
module acs_analog_model(input wire [2:0] active_channel,output wire [11:0] sample);
assign sample = {active_channel, 9'h000};
endmodule // acs_analog_model

/* test/acs_seq_asserts.sv */
`timescale 1ns/1ps
// Sees only the top ports; a field write shows one cycle later
module acs_seq_asserts(input wire mclk,resetn,wr,rd,input wire [7:0] addr,
input wire [31:0] wdata,rdata,input wire [2:0] active_channel,first_step_channel,
second_step_channel,third_step_channel,fourth_step_channel,fifth_step_channel,
sixth_step_channel);
default clocking @(posedge mclk); endclocking
default disable iff (!resetn);
wire w0 = wr && addr == 8'h00; // Select register write
a_first_field: assert property(w0|=>first_step_channel==$past(wdata[2:0])) else $error("f0");
a_second_field: assert property(w0|=>second_step_channel==$past(wdata[6:4])) else $error("f1");
a_third_field: assert property(w0|=>third_step_channel==$past(wdata[10:8])) else $error("f2");
a_fourth_field: assert property(w0|=>fourth_step_channel==$past(wdata[14:12])) else $error("f3");
a_fifth_field: assert property(w0|=>fifth_step_channel==$past(wdata[18:16])) else $error("f4");
a_sixth_field: assert property(w0|=>sixth_step_channel==$past(wdata[22:20])) else $error("f5");
a_rsv_zero: assert property((rdata&32'hFF88_8888)==32'h0000_0000) else $error("reserved");
a_step_route: assert property(wr&&addr==8'h04&&wdata[2:0]==3'h0 ##1 !w0[*2]
    |-> active_channel==first_step_channel) else $error("step route");
endmodule // acs_seq_asserts
bind acs_seq_select acs_seq_asserts chk_u(.*);

/* test/adc_sequence_input_select_test.sv */
`timescale 1ns/1ps
`define CHK(n,e,s) begin compares++; if ((s) !== (e)) begin err_total++; \
$display("FAIL %s exp %0h got %0h", n, e, s); end end
module adc_sequence_input_select_test;
reg mclk = 0, resetn = 0, wr = 0, rd = 0; // Bus master signals
reg [7:0] addr = 0;
reg [31:0] wdata = 0;
wire [31:0] rdata;
wire [2:0] active_channel, first_step_channel, second_step_channel, third_step_channel,
    fourth_step_channel, fifth_step_channel, sixth_step_channel;
wire [11:0] sample; // Level at the selected analog pin
int err_total = 0, compares = 0, cyc = 0;
initial forever #25 mclk = ~mclk;
acs_seq_select dut_u(.*);
acs_analog_model am_u(.active_channel, .sample);
task wrr(input [7:0] a, input [31:0] d);
    @(posedge mclk); addr <= a; wdata <= d; wr <= 1;
    @(posedge mclk); wr <= 0; #1;
endtask
task rdc(input [7:0] a, input [31:0] e);
    @(posedge mclk); addr <= a; rd <= 1;
    @(posedge mclk); rd <= 0; #1;
    `CHK("rdata", e, rdata)
    @(posedge mclk); #1;
    `CHK("rdata idle", 32'h0000_0000, rdata)
endtask
task t_fields;
    rdc(8'h00, 32'h0000_0000);
    wrr(8'h00, 32'hFFFF_FFFF); rdc(8'h00, 32'h0077_7777);
    wrr(8'h00, 32'h0065_4321);
    `CHK("f0", 3'h1, first_step_channel)
    `CHK("f1", 3'h2, second_step_channel)
    `CHK("f2", 3'h3, third_step_channel)
    `CHK("f3", 3'h4, fourth_step_channel)
    `CHK("f4", 3'h5, fifth_step_channel)
    `CHK("f5", 3'h6, sixth_step_channel)
    wrr(8'h40, 32'h0000_0000); rdc(8'h40, 32'h0000_0000);
    rdc(8'h00, 32'h0065_4321);
    $display("field test done");
endtask
// Each step routes its field; value i+1 lands on pin i+1
task t_steps;
    for (int i = 0; i < 6; i++) begin
        wrr(8'h04, i); @(posedge mclk); #1;
        `CHK("chan", 3'(i + 1), active_channel)
        `CHK("pin", {3'(i + 1), 9'h000}, sample)
    end
    rdc(8'h04, 32'h0000_0005);
    wrr(8'h04, 32'h0000_0006); @(posedge mclk); #1;
    `CHK("chan", 3'h0, active_channel)
    $display("step test done");
endtask
task report_and_stop;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
endtask
// Hang guard well above the fifty or so cycles the tests use
always @(posedge mclk) if (++cyc > 2000) begin err_total++; report_and_stop; end
initial begin
    repeat (4) @(posedge mclk); resetn <= 1;
    t_fields; t_steps; report_and_stop;
end
endmodule // adc_sequence_input_select_test
